// *** sapu_map.svh ***
// Constant map of the servo alarm protection unit.
// Assumes inclusion by bare name from the design files.
`ifndef SAPU_MAP_SVH
`define SAPU_MAP_SVH

// Alarm bit values
`define SAPU_E_THERMAL   16'h0004
`define SAPU_E_HEATSINK  16'h0008
`define SAPU_E_PARAM     16'h0010
`define SAPU_E_REVLIM    16'h0040
`define SAPU_E_FWDLIM    16'h0080
`define SAPU_E_ENCODER   16'h0200
`define SAPU_E_OVERSPEED 16'h0400
`define SAPU_E_POSERR    16'h0800
`define SAPU_E_NONE      16'h0000
`define SAPU_E_ALL       16'hffff

// Alarm groups
`define SAPU_TRIP_MASK   16'h021c
`define SAPU_LIMIT_MASK  16'h00c0
`define SAPU_WARN_MASK   16'h0c00
`define SAPU_BRAKE_MASK  16'h02dc

// Thresholds
`define SAPU_HEATSINK_LIMIT_C 8'h50
`define SAPU_OVERSPEED_PCT    8'h6d
`define SAPU_PCT_FULL         8'h64

// Register offsets
`define SAPU_REG_CTRL     8'h00
`define SAPU_REG_CODE     8'h04
`define SAPU_REG_SPDLIM   8'h08
`define SAPU_REG_ERRLIM   8'h0c
`define SAPU_REG_RATED    8'h10
`define SAPU_REG_DISPLAY  8'h14

// Control bits
`define SAPU_CTRL_SERVO_ON  0
`define SAPU_CTRL_RESET     1
`define SAPU_CTRL_SERVO_OFF 2

// Reset values
`define SAPU_SPDLIM_RST 16'h0bb8
`define SAPU_ERRLIM_RST 16'h0400
`define SAPU_RATED_RST  16'h0064

// Cycles for the strap sampler to see synchronised buttons
`define SAPU_STRAP_WAIT 2'h3

`endif

// *** sapu_pkg.sv ***
// Types of the servo alarm protection unit.
// Assumes nothing beyond a SystemVerilog compiler.
package sapu_pkg;

    // Fault detector levels from same-clock logic
    typedef struct packed {
        logic       thermal_trip;   // Motor thermal model tripped
        logic       param_invalid;  // Stored parameters bad
        logic       encoder_fault;  // Encoder signal lost
        logic [7:0] heatsink_temp;  // Heat sink in degrees C
    } sapu_fault_type;

    // Grouped alarm output lines
    typedef struct packed {
        logic trip;     // Trip faults
        logic limit;    // Travel limits
        logic warning;  // Warnings
    } sapu_alarm_out_type;

    // Servo state
    typedef enum logic [1:0] {
        SAPU_OFF     = 2'b00,
        SAPU_ON      = 2'b01,
        SAPU_TRIPPED = 2'b10
    } sapu_servo_state_type;

endpackage

// *** sapu_sync2.sv ***
// Two-flop synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/10ps
module sapu_sync2 import sapu_pkg::*; #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_ff;  // First stage, read only by second

    // Two stages per bit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_ff   <= '0;
            level_out <= '0;
        end else begin
            meta_ff   <= pin_in;
            level_out <= meta_ff;
        end
    end
endmodule

// *** sapu_display.sv ***
// Front panel value: alarm code or output current percentage.
// Assumes current and rated current share one unit.
`timescale 1ns/10ps
`include "sapu_map.svh"
module sapu_display import sapu_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [15:0] alarm_code,
    input  wire logic [15:0] out_current,
    input  wire logic [15:0] rated_current,
    output logic             disp_alarm_ff,
    output logic [15:0]      disp_value_ff
);
    logic [23:0] cur_scaled;  // Current times one hundred
    logic [23:0] cur_pct;     // Percentage of rated
    logic        has_alarm;   // Any alarm bit set

    assign cur_scaled = 24'(out_current) * 24'(`SAPU_PCT_FULL);
    // Zero rated current shows zero, no divide by zero
    assign cur_pct    = (rated_current == 16'h0000) ? 24'h000000
                      : cur_scaled / 24'(rated_current);
    assign has_alarm  = (alarm_code != `SAPU_E_NONE);

    // Code while alarmed, else current percentage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            disp_alarm_ff <= 1'b0;
            disp_value_ff <= 16'h0000;
        end else begin
            disp_alarm_ff <= has_alarm;
            disp_value_ff <= has_alarm ? alarm_code : cur_pct[15:0];
        end
    end

    // Start only out of reset: the register still shows its reset value there
    a_display_idle : assert property (@(posedge clk_sys) disable iff (reset)
        !reset && !has_alarm |=> !disp_alarm_ff && disp_value_ff == $past(cur_pct[15:0]))
        else $error("display not showing current percentage");
endmodule

// *** sapu_top.sv ***
// Servo alarm protection unit: latches faults into a 16-bit alarm code,
// drives the brake, alarm groups, display and status answer.
// Assumes fault levels and measurements come on clk_sys; pins are async.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "sapu_map.svh"
module sapu_top import sapu_pkg::*; (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // Serial command decoder strobes
    input  wire logic               alarm_status_query,
    input  wire logic               alarm_reset_command,
    input  wire logic               param_store_command,
    output logic                    query_valid_ff,
    output logic      [15:0]        query_code_ff,
    output logic                    param_write_grant_ff,
    // Pins
    input  wire logic               forward_limit_in,
    input  wire logic               reverse_limit_in,
    input  wire logic               alarm_clear_in,
    input  wire logic [3:0]         panel_button_in,
    // Detectors and measurements
    input  wire sapu_pkg::sapu_fault_type fault_in,
    input  wire logic [15:0]        motor_speed,
    input  wire logic [15:0]        position_error,
    input  wire logic [15:0]        out_current,
    // Protective outputs
    output sapu_pkg::sapu_alarm_out_type alarm_out_ff,
    output logic                    brake_engage,
    output logic                    servo_enable,
    output logic                    disp_alarm_ff,
    output logic      [15:0]        disp_value_ff
);
    // Synchronised pins
    logic [6:0]  pin_level;        // Synchronised pin group
    logic        fwd_lim;          // Forward limit level
    logic        rev_lim;          // Reverse limit level
    logic        ext_clear;        // Alarm clear level
    logic        ext_clear_d_ff;   // For edge detection
    logic [3:0]  buttons;          // Panel buttons

    // Settings
    logic [15:0] spdlim_ff;        // Speed limit
    logic [15:0] errlim_ff;        // Allowable position error
    logic [15:0] rated_ff;         // Rated current

    // Alarm state
    logic [15:0] alarm_code_ff;    // Active alarm code
    logic [15:0] nxt_alarm_code;   // Next alarm code
    logic [15:0] cause_vec;        // Live causes as bit values
    logic [15:0] hold_mask;        // Trip bits kept this cycle
    logic        clear_req;        // Any reset request
    sapu_alarm_out_type nxt_alarm_out; // Next group lines

    // Servo control
    sapu_servo_state_type state_ff;      // Servo state
    sapu_servo_state_type nxt_state;     // Next servo state
    logic        wr_ctrl;          // Control write
    logic        servo_on_req;     // Servo on request
    logic        servo_off_req;    // Servo off request

    // Parameter unlock strap
    logic [1:0]  strap_cnt_ff;     // Wait for synchroniser
    logic        unlock_ff;        // Button held at start-up
    logic        strap_take;       // Sample moment

    // Comparators
    logic [23:0] speed_scaled;     // Speed times 100
    logic [23:0] limit_scaled;     // Limit times 109
    logic        overspeed;        // Over 109 percent
    logic        pos_excess;       // Position error over limit
    logic        heat_over;        // Heat sink over 80C

    // Register read mux
    logic [31:0] rd_mux;           // Selected read word

    // Pin synchroniser
    sapu_sync2 #(
        .WIDTH (7)
    ) u_sync (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    ({panel_button_in, alarm_clear_in,
                     reverse_limit_in, forward_limit_in}),
        .level_out (pin_level)
    );

    assign fwd_lim   = pin_level[0];
    assign rev_lim   = pin_level[1];
    assign ext_clear = pin_level[2];
    assign buttons   = pin_level[6:3];

    // Threshold comparators
    assign speed_scaled = 24'(motor_speed) * 24'(`SAPU_PCT_FULL);
    assign limit_scaled = 24'(spdlim_ff) * 24'(`SAPU_OVERSPEED_PCT);
    assign overspeed    = speed_scaled > limit_scaled;
    assign pos_excess   = position_error > errlim_ff;
    assign heat_over    = fault_in.heatsink_temp > `SAPU_HEATSINK_LIMIT_C;

    // Live causes as alarm bit values
    assign cause_vec =
        (fault_in.thermal_trip  ? `SAPU_E_THERMAL   : `SAPU_E_NONE)
      | (heat_over              ? `SAPU_E_HEATSINK  : `SAPU_E_NONE)
      | (fault_in.param_invalid ? `SAPU_E_PARAM     : `SAPU_E_NONE)
      | (fault_in.encoder_fault ? `SAPU_E_ENCODER   : `SAPU_E_NONE)
      | (fwd_lim                ? `SAPU_E_FWDLIM    : `SAPU_E_NONE)
      | (rev_lim                ? `SAPU_E_REVLIM    : `SAPU_E_NONE)
      | (overspeed              ? `SAPU_E_OVERSPEED : `SAPU_E_NONE)
      | (pos_excess             ? `SAPU_E_POSERR    : `SAPU_E_NONE);

    // Reset from command, register or clear pin rising edge
    assign wr_ctrl   = reg_wr && (reg_addr == `SAPU_REG_CTRL);
    assign clear_req = alarm_reset_command
                     || (wr_ctrl && reg_wdata[`SAPU_CTRL_RESET])
                     || (ext_clear && !ext_clear_d_ff);

    // On clear keep only bits whose cause remains
    assign hold_mask = clear_req ? cause_vec : `SAPU_E_ALL;
    // Set beats clear; warnings follow their cause
    assign nxt_alarm_code = ((alarm_code_ff & hold_mask)
                           | cause_vec) & `SAPU_BRAKE_MASK
                          | (cause_vec & `SAPU_WARN_MASK);

    assign nxt_alarm_out.trip    = |(nxt_alarm_code & `SAPU_TRIP_MASK);
    assign nxt_alarm_out.limit   = |(nxt_alarm_code & `SAPU_LIMIT_MASK);
    assign nxt_alarm_out.warning = |(nxt_alarm_code & `SAPU_WARN_MASK);

    // Brake follows latched trip and travel limit bits only
    assign brake_engage = |(alarm_code_ff & `SAPU_BRAKE_MASK);
    // Either direction runs again only after the limit bit clears
    assign servo_enable = (state_ff == SAPU_ON);

    // Alarm code and group outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alarm_code_ff  <= `SAPU_E_NONE;
            alarm_out_ff   <= '0;
            ext_clear_d_ff <= 1'b0;
        end else begin
            alarm_code_ff  <= nxt_alarm_code;
            alarm_out_ff   <= nxt_alarm_out;
            ext_clear_d_ff <= ext_clear;
        end
    end

    // Servo state requests
    assign servo_on_req  = wr_ctrl && reg_wdata[`SAPU_CTRL_SERVO_ON];
    assign servo_off_req = wr_ctrl && reg_wdata[`SAPU_CTRL_SERVO_OFF];

    // Servo state transitions
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            // Idle; turn on only without trips
            SAPU_OFF: begin
                if (brake_engage) begin
                    nxt_state = SAPU_TRIPPED;
                end else if (servo_on_req) begin
                    nxt_state = SAPU_ON;
                end
            end
            // Running; any trip turns servo off
            SAPU_ON: begin
                if (brake_engage) begin
                    nxt_state = SAPU_TRIPPED;
                end else if (servo_off_req) begin
                    nxt_state = SAPU_OFF;
                end
            end
            // Braked; leave once all trip and travel limit bits are cleared
            SAPU_TRIPPED: begin
                if (!brake_engage) begin
                    nxt_state = SAPU_OFF;
                end
            end
            default: begin
                nxt_state = SAPU_TRIPPED;
            end
        endcase
    end

    // Servo state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= SAPU_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Button strap sampled once synchronisers settle
    assign strap_take = (strap_cnt_ff == `SAPU_STRAP_WAIT - 2'h1);

    // Start-up unlock capture
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strap_cnt_ff <= 2'h0;
            unlock_ff    <= 1'b0;
        end else begin
            if (strap_cnt_ff != `SAPU_STRAP_WAIT) begin
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            end
            if (strap_take) begin
                unlock_ff <= |buttons;
            end
        end
    end

    // Serial answers and parameter write grant
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            query_valid_ff       <= 1'b0;
            query_code_ff        <= `SAPU_E_NONE;
            param_write_grant_ff <= 1'b0;
        end else begin
            query_valid_ff       <= alarm_status_query;
            if (alarm_status_query) begin
                query_code_ff <= alarm_code_ff;
            end
            // Bad store accepted only with the start-up unlock
            param_write_grant_ff <= param_store_command
                                  && (unlock_ff || !fault_in.param_invalid);
        end
    end

    // Register read selection
    assign rd_mux =
        (reg_addr == `SAPU_REG_CTRL)    ? {30'h0, state_ff}       :
        (reg_addr == `SAPU_REG_CODE)    ? {16'h0, alarm_code_ff}  :
        (reg_addr == `SAPU_REG_SPDLIM)  ? {16'h0, spdlim_ff}      :
        (reg_addr == `SAPU_REG_ERRLIM)  ? {16'h0, errlim_ff}      :
        (reg_addr == `SAPU_REG_RATED)   ? {16'h0, rated_ff}       :
        (reg_addr == `SAPU_REG_DISPLAY) ? {15'h0, disp_alarm_ff,
                                           disp_value_ff}          :
        32'h0000_0000;

    // Setting writes and read data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            spdlim_ff <= `SAPU_SPDLIM_RST;
            errlim_ff <= `SAPU_ERRLIM_RST;
            rated_ff  <= `SAPU_RATED_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_wr && reg_addr == `SAPU_REG_SPDLIM) begin
                spdlim_ff <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == `SAPU_REG_ERRLIM) begin
                errlim_ff <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == `SAPU_REG_RATED) begin
                rated_ff <= reg_wdata[15:0];
            end
            // Data only in the cycle after the strobe
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Front panel
    sapu_display u_disp (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .alarm_code    (alarm_code_ff),
        .out_current   (out_current),
        .rated_current (rated_ff),
        .disp_alarm_ff (disp_alarm_ff),
        .disp_value_ff (disp_value_ff)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Trip cause then a clean reset
    sequence s_tripped;
        brake_engage && !clear_req;
    endsequence
    sequence s_clean_clear;
        clear_req && cause_vec == `SAPU_E_NONE;
    endsequence

    a_trip_brake_on : assert property (
        fault_in.thermal_trip |=> brake_engage ##1 !servo_enable)
        else $error("trip did not brake and stop servo");
    a_group_lines : assert property (
        alarm_out_ff.trip == |(alarm_code_ff & `SAPU_TRIP_MASK)
        && alarm_out_ff.limit == |(alarm_code_ff & `SAPU_LIMIT_MASK)
        && alarm_out_ff.warning == |(alarm_code_ff & `SAPU_WARN_MASK))
        else $error("alarm groups do not match code");
    a_query_answer : assert property (
        alarm_status_query |=> query_valid_ff
        && query_code_ff == $past(alarm_code_ff))
        else $error("status answer differs from code");
    a_reset_release : assert property (
        s_tripped ##1 s_clean_clear |=> !brake_engage ##1 !servo_enable)
        else $error("clean reset did not release brake");
    a_warn_no_brake : assert property (
        (alarm_code_ff & ~`SAPU_WARN_MASK) == `SAPU_E_NONE |-> !brake_engage)
        else $error("warning engaged the brake");
    a_thermal_bit : assert property (
        fault_in.thermal_trip
        |=> |(alarm_code_ff & `SAPU_E_THERMAL) && alarm_out_ff.trip)
        else $error("thermal trip not flagged");
    a_heat_bit : assert property (
        fault_in.heatsink_temp > `SAPU_HEATSINK_LIMIT_C
        |=> |(alarm_code_ff & `SAPU_E_HEATSINK) && alarm_out_ff.trip)
        else $error("heat sink trip not flagged");
    a_param_bit : assert property (
        fault_in.param_invalid
        |=> |(alarm_code_ff & `SAPU_E_PARAM) && alarm_out_ff.trip && brake_engage)
        else $error("parameter error not flagged");
    a_encoder_bit : assert property (
        fault_in.encoder_fault
        |=> |(alarm_code_ff & `SAPU_E_ENCODER) && alarm_out_ff.trip && brake_engage)
        else $error("encoder error not flagged");
    a_fwd_limit : assert property (
        fwd_lim
        |=> |(alarm_code_ff & `SAPU_E_FWDLIM) && alarm_out_ff.limit && brake_engage)
        else $error("forward limit not flagged");
    a_rev_limit : assert property (
        rev_lim
        |=> |(alarm_code_ff & `SAPU_E_REVLIM) && alarm_out_ff.limit && brake_engage)
        else $error("reverse limit not flagged");
    a_overspeed_warn : assert property (
        overspeed
        |=> |(alarm_code_ff & `SAPU_E_OVERSPEED) && alarm_out_ff.warning)
        else $error("overspeed warning missing");
    a_poserr_warn : assert property (
        pos_excess
        |=> |(alarm_code_ff & `SAPU_E_POSERR) && alarm_out_ff.warning)
        else $error("position error warning missing");
    a_code_or : assert property (
        (cause_vec & `SAPU_WARN_MASK) == `SAPU_E_NONE
        |=> (alarm_code_ff & `SAPU_WARN_MASK) == `SAPU_E_NONE)
        else $error("stale warning bit in code");
    a_trip_latched : assert property (
        brake_engage && !clear_req |=> brake_engage)
        else $error("trip bit dropped without reset");
    a_unlock_grant : assert property (
        param_store_command && fault_in.param_invalid && !unlock_ff
        |=> !param_write_grant_ff)
        else $error("store granted without unlock");
endmodule

// *** sapu_host_model.sv ***
// Host discrete I/O model: travel-limit pins and alarm clear pin.
// Assumes the bench calls its tasks; pins are levels seen by a 2-flop sync.
`timescale 1ns/10ps
module sapu_host_model (
    input  wire logic clk_sys,
    output logic      fwd_lim,
    output logic      rev_lim,
    output logic      clr_pin
);
    // Pins start released
    initial begin
        fwd_lim = 1'b0;
        rev_lim = 1'b0;
        clr_pin = 1'b0;
    end
    // Drive the limit sensors
    task automatic set_limits(input logic f, input logic r);
        @(posedge clk_sys);
        fwd_lim <= f;
        rev_lim <= r;
    endtask
    // Cause removed first, then a clear pulse long enough for the sync
    task automatic clear_alarm();
        set_limits(1'b0, 1'b0);
        repeat (3) @(posedge clk_sys);
        clr_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        clr_pin <= 1'b0;
    endtask
endmodule

// *** servo_alarm_protection_unit_bench.sv ***
// Self-checking bench of the servo alarm protection unit.
// Assumes sapu_top with its package and map header compiled first.
`timescale 1ns/10ps
module servo_alarm_protection_unit_bench;
    import sapu_pkg::*;
    logic               clk_sys, reset, reg_wr, reg_rd, asq, arc, psc;
    logic [7:0]         reg_addr;   // Register address
    logic [31:0]        reg_wdata;  // Register write data
    logic [31:0]        reg_rdata;  // Register read data
    logic [31:0]        rv;         // Last read value
    logic [15:0]        spd, perr, cur, qcode, dval;
    logic               qv, grant, fl, rl, cl, brk, sv, dal;
    logic [3:0]         btn;        // Panel buttons
    sapu_fault_type     flt;        // Fault levels
    sapu_alarm_out_type aout;       // Alarm groups
    int                 n_fail, total_checks, cyc;
    // Device under test
    sapu_top dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .alarm_status_query(asq), .alarm_reset_command(arc), .param_store_command(psc),
        .query_valid_ff(qv), .query_code_ff(qcode), .param_write_grant_ff(grant),
        .forward_limit_in(fl), .reverse_limit_in(rl), .alarm_clear_in(cl),
        .panel_button_in(btn), .fault_in(flt), .motor_speed(spd),
        .position_error(perr), .out_current(cur), .alarm_out_ff(aout),
        .brake_engage(brk), .servo_enable(sv), .disp_alarm_ff(dal), .disp_value_ff(dval));
    // Host pins model
    sapu_host_model host_u (.clk_sys(clk_sys), .fwd_lim(fl), .rev_lim(rl), .clr_pin(cl));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end
    // Compare one value
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Wait edges, then let updates land
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Register read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Serial reset command pulse
    task automatic reset_cmd();
        @(posedge clk_sys);
        arc <= 1'b1;
        @(posedge clk_sys);
        arc <= 1'b0;
        wt(3);
    endtask
    // Reset values and unmapped read
    task automatic t_regs();
        rd(8'h08); chk(rv, 32'h0000_0bb8);
        rd(8'h10); chk(rv, 32'h0000_0064);
        rd(8'h20); chk(rv, 32'h0000_0000);
    endtask
    // One trip cause: latch, refused reset, release
    task automatic t_trip(input logic [15:0] code);
        // Servo running first, so the trip has something to stop
        wr(8'h00, 32'h1);
        wt(1);
        chk(sv, 1'b1);
        @(posedge clk_sys);
        flt.thermal_trip <= (code == 16'h0004);
        flt.heatsink_temp <= (code == 16'h0008) ? 8'h51 : 8'h50;
        flt.param_invalid <= (code == 16'h0010);
        flt.encoder_fault <= (code == 16'h0200);
        wt(3);
        rd(8'h04); chk(rv, {16'h0, code});
        chk(aout, 3'b100);
        chk({brk, sv}, 2'b10);
        reset_cmd();
        rd(8'h04); chk(rv, {16'h0, code});
        if (code == 16'h0010) begin
            @(posedge clk_sys);
            psc <= 1'b1;
            @(posedge clk_sys);
            psc <= 1'b0;
            #1 chk(grant, 1'b0);
        end
        @(posedge clk_sys);
        flt <= '{1'b0, 1'b0, 1'b0, 8'h50};
        reset_cmd();
        rd(8'h04); chk(rv, 32'h0);
        chk({brk, aout}, 4'h0);
    endtask
    // Travel limit: latch, host clear, servo back on
    task automatic t_limit(input logic f, input logic [15:0] code);
        host_u.set_limits(f, !f);
        wt(4);
        rd(8'h04); chk(rv, {16'h0, code});
        chk({brk, aout}, 4'b1010);
        host_u.clear_alarm();
        wt(4);
        chk(brk, 1'b0);
        wr(8'h00, 32'h1);
        wt(2);
        chk(sv, 1'b1);
    endtask
    // Warnings: thresholds, no brake
    task automatic t_warn();
        spd <= 16'd3270;
        wt(3);
        chk(aout, 3'b000);
        spd <= 16'd3271;
        perr <= 16'h0401;
        wt(3);
        rd(8'h04); chk(rv, 32'h0c00);
        chk({brk, sv, aout}, 5'b01001);
        rd(8'h00);
        chk(rv, 32'h1);
        spd <= 16'd0;
        perr <= 16'h0400;
        wt(3);
        chk(aout, 3'b000);
        // Servo off command returns the state to off
        wr(8'h00, 32'h4);
        rd(8'h00);
        chk(rv, 32'h0);
    endtask
    // Two causes, query and display agree
    task automatic t_combo();
        flt.thermal_trip <= 1'b1;
        host_u.set_limits(1'b0, 1'b1);
        wt(4);
        asq <= 1'b1;
        @(posedge clk_sys);
        asq <= 1'b0;
        #1 chk({qv, qcode}, 17'h1_0044);
        rd(8'h14); chk(rv, 32'h1_0044);
        chk(dval, 16'h0044);
        flt.thermal_trip <= 1'b0;
        host_u.clear_alarm();
        wt(4);
        // Rated current 200: 50 shows as 25 percent
        wr(8'h10, 32'h0000_00c8);
        cur <= 16'h0032;
        wt(4);
        chk({dal, dval}, 17'h0_0019);
    endtask
    // Button held through a mid-run reset unlocks a bad store
    task automatic t_unlock();
        @(posedge clk_sys);
        btn <= 4'h4;
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        flt.param_invalid <= 1'b1;
        wt(3);
        chk({brk, aout}, 4'b1100);
        @(posedge clk_sys);
        psc <= 1'b1;
        @(posedge clk_sys);
        psc <= 1'b0;
        btn <= 4'h0;
        #1 chk(grant, 1'b1);
        @(posedge clk_sys);
        flt.param_invalid <= 1'b0;
        // Clear through the control register this time
        wr(8'h00, 32'h2);
        wt(1);
        chk({brk, aout}, 4'h0);
    endtask
    // Verdict
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset, reg_wr, reg_rd, asq, arc, psc} = 6'b100000;
        {reg_addr, reg_wdata, spd, perr, cur, btn} = '0;
        flt = '{1'b0, 1'b0, 1'b0, 8'h50};
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        wt(1);
        t_regs();
        t_trip(16'h0004);
        t_trip(16'h0008);
        t_trip(16'h0010);
        t_trip(16'h0200);
        t_limit(1'b1, 16'h0080);
        t_limit(1'b0, 16'h0040);
        t_warn();
        t_combo();
        t_unlock();
        end_of_test();
    end
endmodule
